// ### logic/input_clamp_bias_control.sv
// clamp pulse generation and input bias settings
//
// Functional notes
// - clamp pulse starts programmed pixels after shift pulse, lasts programmed pixels.
// - when gating selected, clamp switch follows clamp pulse AND sample clock.
// - clamp switch closes while the (gated or ungated) pulse is active.
// - source followers on all three inputs enabled by config 1 bit 7.
// - after reset clamp reference comes from divider at half the analog supply.
// - divider can be disconnected so the reference pin is driven externally.
// - reference select 01 connects the reference DAC buffer to the pin.
// - DAC code bits 3:0 offset binary, 1000 mid scale, 1111 full scale.
// - in CDS mode, dividers can bias any of the three inputs, no clamp.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module input_clamp_bias_control #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rdata,
    // pixel timing from outside the block's logic
    input  wire logic        sensor_shift_pulse,
    input  wire logic        sample_clk,
    // analog controls
    output logic             input_clamp_pulse,
    output logic             gated_clamp_pulse,
    output logic             clamp_switch,
    output logic [2:0]       follower_en,
    output logic             range_1v2,
    output logic             ref_divider_en,
    output logic             ref_dac_en,
    output logic [3:0]       ref_dac_code,
    output logic [2:0]       cds_bias_en
);
    // ==========================================================
    // input synchronisers
    logic [1:0] shift_sync_ff;
    logic [1:0] nxt_shift_sync;
    logic [1:0] smp_sync_ff;
    logic [1:0] nxt_smp_sync;
    logic       shift_prev_ff;
    logic       nxt_shift_prev;
    logic       shift_rise;

    always_comb begin
        nxt_shift_sync = {shift_sync_ff[0], sensor_shift_pulse};
        nxt_smp_sync   = {smp_sync_ff[0], sample_clk};
        nxt_shift_prev = shift_sync_ff[1];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_sync_ff <= 2'h0;
            smp_sync_ff   <= 2'h0;
            shift_prev_ff <= 1'b0;
        end else begin
            shift_sync_ff <= nxt_shift_sync;
            smp_sync_ff   <= nxt_smp_sync;
            shift_prev_ff <= nxt_shift_prev;
        end
    end

    assign shift_rise = shift_sync_ff[1] & ~shift_prev_ff;

    // ==========================================================
    // registers
    logic [7:0] cfg1_ff, nxt_cfg1;
    logic [7:0] cfg2_ff, nxt_cfg2;
    logic [7:0] ref_ff, nxt_ref;
    logic [7:0] delay_ff, nxt_delay;
    logic [7:0] width_ff, nxt_width;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] nxt_rdata;
    logic       pulse_ff;
    logic       gated_ff;
    logic       switch_ff;

    always_comb begin
        nxt_cfg1  = cfg1_ff;
        nxt_cfg2  = cfg2_ff;
        nxt_ref   = ref_ff;
        nxt_delay = delay_ff;
        nxt_width = width_ff;
        nxt_ctrl  = ctrl_ff;
        if (wr_en) begin
            if (addr == clamp_bias_pkg::ADDR_MAIN_CFG1) begin
                nxt_cfg1 = wdata;
            end else if (addr == clamp_bias_pkg::ADDR_MAIN_CFG2) begin
                nxt_cfg2 = wdata;
            end else if (addr == clamp_bias_pkg::ADDR_CLAMP_REF) begin
                nxt_ref = wdata;
            end else if (addr == clamp_bias_pkg::ADDR_CLAMP_DELAY) begin
                nxt_delay = wdata;
            end else if (addr == clamp_bias_pkg::ADDR_CLAMP_WIDTH) begin
                nxt_width = wdata;
            end else if (addr == clamp_bias_pkg::ADDR_CLAMP_CTRL) begin
                nxt_ctrl = wdata;
            end
        end
        // unmapped reads and idle cycles return zero
        nxt_rdata = 8'h00;
        if (rd_en) begin
            if (addr == clamp_bias_pkg::ADDR_MAIN_CFG1) begin
                nxt_rdata = cfg1_ff;
            end else if (addr == clamp_bias_pkg::ADDR_MAIN_CFG2) begin
                nxt_rdata = cfg2_ff;
            end else if (addr == clamp_bias_pkg::ADDR_CLAMP_REF) begin
                nxt_rdata = ref_ff;
            end else if (addr == clamp_bias_pkg::ADDR_CLAMP_DELAY) begin
                nxt_rdata = delay_ff;
            end else if (addr == clamp_bias_pkg::ADDR_CLAMP_WIDTH) begin
                nxt_rdata = width_ff;
            end else if (addr == clamp_bias_pkg::ADDR_CLAMP_CTRL) begin
                nxt_rdata = ctrl_ff;
            end else if (addr == clamp_bias_pkg::ADDR_STATUS) begin
                nxt_rdata = {5'h00, switch_ff, gated_ff, pulse_ff};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg1_ff  <= clamp_bias_pkg::CFG1_RESET;
            cfg2_ff  <= clamp_bias_pkg::CFG2_RESET;
            ref_ff   <= clamp_bias_pkg::REF_RESET;
            delay_ff <= clamp_bias_pkg::DELAY_RESET;
            width_ff <= clamp_bias_pkg::WIDTH_RESET;
            ctrl_ff  <= clamp_bias_pkg::CTRL_RESET;
            rdata    <= 8'h00;
        end else begin
            cfg1_ff  <= nxt_cfg1;
            cfg2_ff  <= nxt_cfg2;
            ref_ff   <= nxt_ref;
            delay_ff <= nxt_delay;
            width_ff <= nxt_width;
            ctrl_ff  <= nxt_ctrl;
            rdata    <= nxt_rdata;
        end
    end

    // ==========================================================
    // clamp pulse sequencer, one count per pixel clock
    clamp_bias_pkg::clamp_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic             nxt_pulse;
    logic             nxt_gated;
    logic             nxt_switch;
    logic             gate_sel;

    assign gate_sel = ctrl_ff[clamp_bias_pkg::GATE_BIT];

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        // a new shift pulse restarts the line whatever the state
        if (shift_rise) begin
            nxt_cnt = CNT_W'(0);
            if (delay_ff[CNT_W-1:0] != CNT_W'(0)) begin
                nxt_state = clamp_bias_pkg::ST_DELAY;
            end else if (width_ff[CNT_W-1:0] != CNT_W'(0)) begin
                nxt_state = clamp_bias_pkg::ST_PULSE;
            end else begin
                nxt_state = clamp_bias_pkg::ST_IDLE;
            end
        end else begin
            case (state_ff)
                clamp_bias_pkg::ST_DELAY: begin
                    if (cnt_ff == delay_ff[CNT_W-1:0] - CNT_W'(1)) begin
                        nxt_cnt = CNT_W'(0);
                        if (width_ff[CNT_W-1:0] != CNT_W'(0)) begin
                            nxt_state = clamp_bias_pkg::ST_PULSE;
                        end else begin
                            nxt_state = clamp_bias_pkg::ST_IDLE;
                        end
                    end else begin
                        nxt_cnt = cnt_ff + CNT_W'(1);
                    end
                end
                clamp_bias_pkg::ST_PULSE: begin
                    if (cnt_ff == width_ff[CNT_W-1:0] - CNT_W'(1)) begin
                        nxt_cnt   = CNT_W'(0);
                        nxt_state = clamp_bias_pkg::ST_IDLE;
                    end else begin
                        nxt_cnt = cnt_ff + CNT_W'(1);
                    end
                end
                default: begin
                    nxt_state = clamp_bias_pkg::ST_IDLE;
                    nxt_cnt   = CNT_W'(0);
                end
            endcase
        end
        nxt_pulse  = (nxt_state == clamp_bias_pkg::ST_PULSE);
        nxt_gated  = nxt_pulse & smp_sync_ff[1];
        // cds divider bias replaces the clamp entirely
        nxt_switch = ~ctrl_ff[clamp_bias_pkg::CDS_BIAS_BIT]
                     & (gate_sel ? nxt_gated : nxt_pulse);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff  <= clamp_bias_pkg::ST_IDLE;
            cnt_ff    <= CNT_W'(0);
            pulse_ff  <= 1'b0;
            gated_ff  <= 1'b0;
            switch_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            pulse_ff  <= nxt_pulse;
            gated_ff  <= nxt_gated;
            switch_ff <= nxt_switch;
        end
    end

    // ==========================================================
    // analog settings, all registered
    logic [1:0] ref_sel;
    logic [2:0] nxt_follower;
    logic [2:0] nxt_cds_bias;
    logic       nxt_div_en;
    logic       nxt_dac_en;
    logic       follower_ff_q;
    logic [2:0] follower_ff;
    logic       range_ff;
    logic       div_en_ff;
    logic       dac_en_ff;
    logic [3:0] dac_code_ff;
    logic [2:0] cds_bias_ff;

    assign ref_sel = ref_ff[clamp_bias_pkg::REF_SEL_HI:clamp_bias_pkg::REF_SEL_LO];
    assign follower_ff_q = cfg1_ff[clamp_bias_pkg::FOLLOWER_BIT];

    always_comb begin
        // range is software's concern; followers obey bit 7 regardless
        nxt_follower = {3{follower_ff_q}};
        nxt_div_en   = (ref_sel == clamp_bias_pkg::REF_DIVIDER);
        nxt_dac_en   = (ref_sel == clamp_bias_pkg::REF_DAC);
        nxt_cds_bias = ctrl_ff[clamp_bias_pkg::CDS_BIAS_BIT]
                       ? ctrl_ff[clamp_bias_pkg::BIAS_CH_HI:clamp_bias_pkg::BIAS_CH_LO]
                       : 3'h0;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            follower_ff <= 3'h0;
            range_ff    <= 1'b0;
            div_en_ff   <= 1'b1;
            dac_en_ff   <= 1'b0;
            dac_code_ff <= clamp_bias_pkg::DAC_MID;
            cds_bias_ff <= 3'h0;
        end else begin
            follower_ff <= nxt_follower;
            range_ff    <= cfg2_ff[clamp_bias_pkg::RANGE_BIT];
            div_en_ff   <= nxt_div_en;
            dac_en_ff   <= nxt_dac_en;
            dac_code_ff <= ref_ff[clamp_bias_pkg::DAC_HI:0];
            cds_bias_ff <= nxt_cds_bias;
        end
    end

    assign input_clamp_pulse = pulse_ff;
    assign gated_clamp_pulse = gated_ff;
    assign clamp_switch      = switch_ff;
    assign follower_en       = follower_ff;
    assign range_1v2         = range_ff;
    assign ref_divider_en    = div_en_ff;
    assign ref_dac_en        = dac_en_ff;
    assign ref_dac_code      = dac_code_ff;
    assign cds_bias_en       = cds_bias_ff;
endmodule
`default_nettype wire

// ### pkg/clamp_bias_pkg.sv
// constants for the input clamp and bias control block
package clamp_bias_pkg;
    // register indices on the strobed register port
    localparam logic [3:0] ADDR_MAIN_CFG1   = 4'h1;
    localparam logic [3:0] ADDR_MAIN_CFG2   = 4'h2;
    localparam logic [3:0] ADDR_CLAMP_REF   = 4'h4;
    localparam logic [3:0] ADDR_CLAMP_DELAY = 4'h5;
    localparam logic [3:0] ADDR_CLAMP_WIDTH = 4'h6;
    localparam logic [3:0] ADDR_CLAMP_CTRL  = 4'h7;
    localparam logic [3:0] ADDR_STATUS      = 4'h8;
    // field positions
    localparam int FOLLOWER_BIT   = 7;
    localparam int RANGE_BIT      = 4;
    localparam int REF_SEL_HI     = 5;
    localparam int REF_SEL_LO     = 4;
    localparam int DAC_HI         = 3;
    localparam int GATE_BIT       = 0;
    localparam int CDS_BIAS_BIT   = 1;
    localparam int BIAS_CH_HI     = 4;
    localparam int BIAS_CH_LO     = 2;
    // clamp reference sources
    localparam logic [1:0] REF_DIVIDER  = 2'h0;
    localparam logic [1:0] REF_DAC      = 2'h1;
    localparam logic [1:0] REF_EXTERNAL = 2'h2;
    // reset values
    localparam logic [7:0] CFG1_RESET   = 8'h00;
    localparam logic [7:0] CFG2_RESET   = 8'h00;
    localparam logic [7:0] REF_RESET    = 8'h08;
    localparam logic [7:0] DELAY_RESET  = 8'h00;
    localparam logic [7:0] WIDTH_RESET  = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [3:0] DAC_MID      = 4'h8;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DELAY = 3'b010,
        ST_PULSE = 3'b100
    } clamp_state_t;
endpackage

// ### verif/input_clamp_bias_control_props.sv
// concurrent checks on the clamp and bias control ports
`timescale 1ns/1ns
`default_nettype none
module input_clamp_bias_control_props (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    // analog controls
    input wire logic       input_clamp_pulse,
    input wire logic       gated_clamp_pulse,
    input wire logic       clamp_switch,
    input wire logic [2:0] follower_en,
    input wire logic       ref_divider_en,
    input wire logic       ref_dac_en,
    input wire logic [3:0] ref_dac_code,
    input wire logic [2:0] cds_bias_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================
    // checks
    chk_gated_and: assert property (gated_clamp_pulse |-> input_clamp_pulse)
        else $error("gated pulse without clamp pulse");
    chk_switch_source: assert property (clamp_switch |-> input_clamp_pulse)
        else $error("clamp switch closed outside clamp pulse");
    chk_reset_defaults: assert property ($fell(rst) |-> ref_divider_en && !ref_dac_en && ref_dac_code == 4'h8)
        else $error("reference defaults wrong after reset");
    chk_ref_exclusive: assert property (!(ref_divider_en && ref_dac_en))
        else $error("divider and dac both on the reference pin");
    chk_dac_select: assert property (wr_en && addr == clamp_bias_pkg::ADDR_CLAMP_REF
        |-> ##2 ref_dac_en == ($past(wdata[5:4], 2) == 2'h1))
        else $error("dac buffer select wrong");
    chk_dac_code: assert property (wr_en && addr == clamp_bias_pkg::ADDR_CLAMP_REF
        |-> ##2 ref_dac_code == $past(wdata[3:0], 2))
        else $error("dac code wrong");
    chk_follower_write: assert property (wr_en && addr == clamp_bias_pkg::ADDR_MAIN_CFG1
        |-> ##2 follower_en == {3{$past(wdata[7], 2)}})
        else $error("follower enables wrong");
    chk_cds_no_clamp: assert property (cds_bias_en != 3'h0 |-> !clamp_switch)
        else $error("clamp switch closed during cds bias");
endmodule
bind input_clamp_bias_control input_clamp_bias_control_props u_props (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .input_clamp_pulse(input_clamp_pulse), .gated_clamp_pulse(gated_clamp_pulse),
    .clamp_switch(clamp_switch), .follower_en(follower_en), .ref_divider_en(ref_divider_en),
    .ref_dac_en(ref_dac_en), .ref_dac_code(ref_dac_code), .cds_bias_en(cds_bias_en));
`default_nettype wire

// ### verif/input_clamp_bias_control_tb.sv
// self-checking bench for the clamp and bias control block
`timescale 1ns/1ns
`default_nettype none
module input_clamp_bias_control_tb;
    logic       mclk = 0, rst = 1, wr_en = 0, rd_en = 0, shift_pin = 0, sc = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic       icp, gcp, sw, r12, rde, rdac;
    logic [2:0] fol, cds;
    logic [3:0] code;
    int         err_count = 0, checks_done = 0;
    always #25 mclk = ~mclk;
    input_clamp_bias_control uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .sensor_shift_pulse(shift_pin), .sample_clk(sc), .input_clamp_pulse(icp),
        .gated_clamp_pulse(gcp), .clamp_switch(sw), .follower_en(fol), .range_1v2(r12),
        .ref_divider_en(rde), .ref_dac_en(rdac), .ref_dac_code(code), .cds_bias_en(cds));
    // ==========================================
    // tasks
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a; rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask
    // one line: shift pulse with delay d, width w, control byte c, sample clock s held
    task automatic line(input logic [7:0] d, input logic [7:0] w, input logic [7:0] c, input logic s);
        int first, np, ns, ng;
        first = -1; np = 0; ns = 0; ng = 0;
        wr(clamp_bias_pkg::ADDR_CLAMP_DELAY, d);
        wr(clamp_bias_pkg::ADDR_CLAMP_WIDTH, w);
        wr(clamp_bias_pkg::ADDR_CLAMP_CTRL, c);
        sc <= s;
        repeat (4) @(posedge mclk);
        chk("cds bias", {5'h0, c[1] ? c[4:2] : 3'h0}, {5'h0, cds});
        shift_pin <= 1'b1;
        for (int k = 1; k <= 30; k++) begin
            @(posedge mclk);
            if (k == 6) shift_pin <= 1'b0;
            #1;
            if (icp === 1'b1 && first < 0) first = k;
            np += (icp === 1'b1);
            ns += (sw === 1'b1);
            ng += (gcp === 1'b1);
        end
        if (w != 0) chk("clamp start", 8'(3 + d), 8'(first));
        chk("clamp width", w, 8'(np));
        chk("gated width", s ? w : 8'h0, 8'(ng));
        chk("switch width", c[1] ? 8'h0 : (c[0] ? (s ? w : 8'h0) : w), 8'(ns));
        $display("test line d=%0d w=%0d ctrl=%h done", d, w, c);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        logic [3:0] codes [4] = '{4'h7, 4'h8, 4'h9, 4'hf};
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        #1 chk("divider on", 8'h1, {7'h0, rde});
        chk("dac code", 8'h08, {4'h0, code});
        rd(clamp_bias_pkg::ADDR_CLAMP_REF, clamp_bias_pkg::REF_RESET);
        $display("test reset done");
        wr(clamp_bias_pkg::ADDR_MAIN_CFG1, 8'h80);
        wr(clamp_bias_pkg::ADDR_MAIN_CFG2, 8'h10);
        repeat (3) @(posedge mclk);
        #1 chk("followers", 8'h07, {5'h0, fol});
        chk("range", 8'h01, {7'h0, r12});
        rd(clamp_bias_pkg::ADDR_MAIN_CFG1, 8'h80);
        wr(clamp_bias_pkg::ADDR_MAIN_CFG1, 8'h00);
        $display("test followers done");
        for (int i = 0; i < 4; i++) begin
            wr(clamp_bias_pkg::ADDR_CLAMP_REF, {2'h0, 2'(i), codes[i]});
            repeat (3) @(posedge mclk);
            #1 chk("divider sel", {7'h0, i == 0}, {7'h0, rde});
            chk("dac sel", {7'h0, i == 1}, {7'h0, rdac});
            chk("dac code", {4'h0, codes[i]}, {4'h0, code});
        end
        $display("test reference done");
        line(8'd2, 8'd3, 8'h00, 1'b0);
        line(8'd0, 8'd2, 8'h00, 1'b1);
        line(8'd3, 8'd0, 8'h00, 1'b0);
        line(8'd2, 8'd3, 8'h01, 1'b1);
        line(8'd2, 8'd3, 8'h01, 1'b0);
        line(8'd1, 8'd2, 8'h1e, 1'b0);
        line(8'd1, 8'd2, 8'h06, 1'b1);
        // status readback while a long pulse stands, then after it ends
        wr(clamp_bias_pkg::ADDR_CLAMP_DELAY, 8'h00);
        wr(clamp_bias_pkg::ADDR_CLAMP_WIDTH, 8'd20);
        wr(clamp_bias_pkg::ADDR_CLAMP_CTRL, 8'h00);
        sc <= 1'b1;
        repeat (3) @(posedge mclk);
        shift_pin <= 1'b1;
        repeat (5) @(posedge mclk);
        rd(clamp_bias_pkg::ADDR_STATUS, 8'h07);
        shift_pin <= 1'b0;
        repeat (25) @(posedge mclk);
        rd(clamp_bias_pkg::ADDR_STATUS, 8'h00);
        $display("test status done");
        wr(4'hf, 8'h55);
        rd(4'hf, 8'h00);
        rd(4'h3, 8'h00);
        $display("test unmapped done");
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
